// file: src/mas_alu_exec.sv
// Execution unit: subtract, nibble exchange, zero skips, table fetch, exclusive-OR
`timescale 1ns/1ps
`include "mas_regs.svh"
module mas_alu_exec (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic      [11:0] paddr_in,
  input  wire logic      [31:0] pwdata_in,
  output logic           [31:0] prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  input  wire logic             op_valid_in,
  input  wire mas_pkg::mas_op_t op_code_in,
  input  wire logic       [7:0] op_addr_in,
  input  wire logic       [2:0] op_bit_in,
  input  wire logic       [7:0] op_literal_in,
  input  wire logic      [13:0] pc_in,
  output logic                  op_ready_out,
  output logic                  op_done_out,
  output logic                  skip_out,
  output logic                  dummy_cycle_out,
  output logic           [13:0] prog_addr_out,
  input  wire logic      [15:0] prog_data_in,
  output logic            [7:0] acc_out,
  output logic            [3:0] flags_out,
  output logic            [7:0] table_high_byte_out
);
  import mas_pkg::*;

  mas_state_t    state;
  mas_op_t       op_q;
  mas_alu_mode_t alu_mode;
  logic [7:0]    addr_q;
  logic [7:0]    lit_q;
  logic [2:0]    bit_q;
  logic [7:0]    acc;
  logic [3:0]    flags;
  logic [7:0]    table_pointer;
  logic [7:0]    table_high_byte;
  logic [13:0]   prog_addr;
  logic          last_skip;
  logic          accept;
  logic          in_exec;
  logic          skip_take;
  logic          mem_dest;
  logic          acc_dest;
  logic          ram_we;
  logic [7:0]    ram_waddr;
  logic [7:0]    ram_wdata;
  logic [7:0]    ram_rdata;
  logic [7:0]    alu_b;
  logic [7:0]    alu_result;
  logic          alu_carry;
  logic          alu_aux;
  logic          alu_ovf;
  logic          alu_zero;
  logic [7:0]    prog_hi;
  logic          apb_setup;
  logic          apb_wr;
  logic          apb_ram_wr;
  logic          apb_err;
  logic [31:0]   next_prdata;

  assign accept    = op_valid_in && (state == ST_IDLE);
  assign in_exec   = (state == ST_EXEC);
  assign prog_hi   = prog_data_in[15:8];
  assign apb_setup = psel_in && !penable_in;
  assign apb_wr    = psel_in && penable_in && pwrite_in;
  assign apb_ram_wr = apb_wr && (paddr_in[11:10] == `MAS_RAM_SEL) && (state == ST_IDLE);

  // Zero byte or zero bit discards the prefetched word
  assign skip_take = in_exec &&
                     (((op_q == OP_SKIP_ON_ZERO) && (ram_rdata == 8'h00)) ||
                      ((op_q == OP_SKIP_ON_BIT_ZERO) && !ram_rdata[bit_q]));

  assign mem_dest = (op_q == OP_SUBTRACT_TO_MEM) || (op_q == OP_NIBBLE_EXCHANGE_MEM) ||
                    (op_q == OP_EXCLUSIVE_OR_TO_MEM);
  assign acc_dest = (op_q == OP_SUB_FROM_ACC) || (op_q == OP_SUB_IMM) ||
                    (op_q == OP_NIBBLE_EXCHANGE_TO_ACC) || (op_q == OP_XOR_TO_ACC) ||
                    (op_q == OP_XOR_IMM);

  assign op_ready_out    = (state == ST_IDLE);
  assign skip_out        = skip_take;
  assign dummy_cycle_out = (state == ST_DUMMY);
  assign op_done_out     = (in_exec && !skip_take) || (state == ST_DUMMY) ||
                           (state == ST_STORE);
  assign prog_addr_out   = prog_addr;
  assign acc_out         = acc;
  assign flags_out       = flags;
  assign table_high_byte_out = table_high_byte;
  assign pready_out      = 1'b1;

  always_comb begin
    alu_b = ram_rdata;
    if ((op_q == OP_SUB_IMM) || (op_q == OP_XOR_IMM)) begin
      alu_b = lit_q;
    end
    case (op_q)
      OP_SUB_FROM_ACC, OP_SUBTRACT_TO_MEM, OP_SUB_IMM: alu_mode = ALU_SUB;
      OP_NIBBLE_EXCHANGE_MEM, OP_NIBBLE_EXCHANGE_TO_ACC: alu_mode = ALU_SWAP;
      default: alu_mode = ALU_XOR;
    endcase
  end

  mas_alu u_alu (
    .a_in       (acc),
    .b_in       (alu_b),
    .mode_in    (alu_mode),
    .result_out (alu_result),
    .carry_out  (alu_carry),
    .aux_out    (alu_aux),
    .ovf_out    (alu_ovf),
    .zero_out   (alu_zero)
  );

  // Memory writes: ALU results, table low byte, software preload while idle
  always_comb begin
    ram_we    = apb_ram_wr || (in_exec && mem_dest) || (state == ST_STORE);
    ram_waddr = addr_q;
    ram_wdata = alu_result;
    if (apb_ram_wr) begin
      ram_waddr = paddr_in[9:2];
      ram_wdata = pwdata_in[7:0];
    end else if (state == ST_STORE) begin
      ram_wdata = prog_data_in[7:0];
    end
  end

  mas_data_ram u_ram (
    .clk_in    (clk_in),
    .we_in     (ram_we),
    .waddr_in  (ram_waddr),
    .wdata_in  (ram_wdata),
    .raddr_in  (addr_q),
    .rdata_out (ram_rdata)
  );

  // Sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            case (op_code_in)
              OP_TABLE_FETCH_CURRENT_PAGE, OP_TABLE_FETCH_LAST_PAGE: state <= ST_FETCH;
              OP_SUB_IMM, OP_XOR_IMM: state <= ST_EXEC;
              default: state <= ST_READ;
            endcase
          end
        end
        ST_READ:  state <= ST_EXEC;
        ST_EXEC:  state <= skip_take ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: state <= ST_IDLE;
        ST_FETCH: state <= ST_STORE;
        ST_STORE: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Operand capture
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      op_q   <= OP_SUB_FROM_ACC;
      addr_q <= 8'h00;
      lit_q  <= 8'h00;
      bit_q  <= 3'h0;
    end else if (accept) begin
      op_q   <= op_code_in;
      addr_q <= op_addr_in;
      lit_q  <= op_literal_in;
      bit_q  <= op_bit_in;
    end
  end

  // Program address of the table word
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prog_addr <= `MAS_RST_PROG;
    end else if (accept && (op_code_in == OP_TABLE_FETCH_LAST_PAGE)) begin
      prog_addr <= {`MAS_LAST_PAGE, table_pointer};
    end else if (accept && (op_code_in == OP_TABLE_FETCH_CURRENT_PAGE)) begin
      prog_addr <= {pc_in[13:8], table_pointer};
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      table_high_byte <= `MAS_RST_THIGH;
    end else if (state == ST_STORE) begin
      table_high_byte <= prog_hi;
    end
  end

  // Accumulator: instruction results win over software writes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc <= `MAS_RST_ACC;
    end else if (in_exec && acc_dest) begin
      acc <= alu_result;
    end else if (apb_wr && (paddr_in == `MAS_ADDR_ACC)) begin
      acc <= pwdata_in[7:0];
    end
  end

  // Flags; exchange, skip and table operations leave them alone
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flags <= `MAS_RST_FLAGS;
    end else if (in_exec) begin
      case (op_q)
        OP_SUB_FROM_ACC, OP_SUB_IMM: begin
          flags[`MAS_FLAG_C]   <= alu_carry;
          flags[`MAS_FLAG_AUX] <= alu_aux;
          flags[`MAS_FLAG_Z]   <= alu_zero;
          flags[`MAS_FLAG_OVF] <= alu_ovf;
        end
        OP_SUBTRACT_TO_MEM: begin
          flags[`MAS_FLAG_C]   <= alu_carry;
          flags[`MAS_FLAG_OVF] <= alu_ovf;
        end
        OP_XOR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEM, OP_XOR_IMM: begin
          flags[`MAS_FLAG_Z]   <= alu_zero;
        end
        default: begin
          flags <= flags;
        end
      endcase
    end else if (apb_wr && (paddr_in == `MAS_ADDR_FLAGS)) begin
      flags <= pwdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      table_pointer <= `MAS_RST_TPTR;
    end else if (apb_wr && (paddr_in == `MAS_ADDR_TPTR)) begin
      table_pointer <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      last_skip <= 1'b0;
    end else if (in_exec) begin
      last_skip <= skip_take;
    end
  end

  // APB read data captured in the setup phase, zero wait states
  always_comb begin
    next_prdata = 32'h0000_0000;
    apb_err     = 1'b0;
    case (paddr_in)
      `MAS_ADDR_ACC:    next_prdata = {24'h000000, acc};
      `MAS_ADDR_FLAGS:  next_prdata = {28'h0000000, flags};
      `MAS_ADDR_TPTR:   next_prdata = {24'h000000, table_pointer};
      `MAS_ADDR_THIGH:  begin
        next_prdata = {24'h000000, table_high_byte};
        apb_err     = pwrite_in;
      end
      `MAS_ADDR_STATUS: begin
        next_prdata = {30'h00000000, last_skip, (state != ST_IDLE)};
        apb_err     = pwrite_in;
      end
      default: begin
        apb_err = (paddr_in[11:10] != `MAS_RAM_SEL) || !pwrite_in || (paddr_in[1:0] != 2'h0);
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_setup && !pwrite_in) begin
      prdata_out <= next_prdata;
    end
  end

  assign pslverr_out = psel_in && penable_in && apb_err;

  property p_sub_acc;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_SUB_FROM_ACC) |=>
      {flags[`MAS_FLAG_C], acc} == mas_sub($past(acc), $past(ram_rdata));
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong");

  property p_sub_mem;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_SUBTRACT_TO_MEM) |->
      ram_we && ram_wdata == 8'(acc - ram_rdata)
      ##1 acc == $past(acc) && flags[`MAS_FLAG_Z] == $past(flags[`MAS_FLAG_Z])
      && flags[`MAS_FLAG_AUX] == $past(flags[`MAS_FLAG_AUX]);
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");

  property p_sub_imm;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_SUB_IMM) |=> {flags[`MAS_FLAG_C], acc} == mas_sub($past(acc), $past(lit_q));
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("subtract literal wrong");

  property p_swap_mem;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_NIBBLE_EXCHANGE_MEM) |->
      ram_we && ram_wdata == mas_swap(ram_rdata) ##1 flags == $past(flags);
  endproperty
  a_swap_mem: assert property (p_swap_mem) else $error("nibble exchange wrong");

  property p_swap_acc;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_NIBBLE_EXCHANGE_TO_ACC) |->
      !ram_we ##1 acc == mas_swap($past(ram_rdata)) && flags == $past(flags);
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("exchange to acc wrong");

  property p_skip_zero;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_SKIP_ON_ZERO) |->
      if (ram_rdata == 8'h00) (skip_out ##1 dummy_cycle_out && op_done_out ##1 op_ready_out)
      else (op_done_out && !skip_out ##1 op_ready_out);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("byte skip wrong");

  property p_skip_bit;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_SKIP_ON_BIT_ZERO) |->
      (skip_out == !ram_rdata[bit_q]) ##1 flags == $past(flags);
  endproperty
  a_skip_bit: assert property (p_skip_bit) else $error("bit skip wrong");

  property p_tab_cur;
    @(posedge clk_in) disable iff (reset_in)
    (state == ST_FETCH && op_q == OP_TABLE_FETCH_CURRENT_PAGE) |->
      prog_addr_out == {$past(pc_in[13:8]), table_pointer}
      ##1 ram_we && ram_wdata == prog_data_in[7:0]
      ##1 table_high_byte == $past(prog_hi);
  endproperty
  a_tab_cur: assert property (p_tab_cur) else $error("current page fetch wrong");

  property p_tab_last;
    @(posedge clk_in) disable iff (reset_in)
    (state == ST_FETCH && op_q == OP_TABLE_FETCH_LAST_PAGE) |->
      prog_addr_out[13:8] == `MAS_LAST_PAGE ##1 ram_we ##1 table_high_byte == $past(prog_hi);
  endproperty
  a_tab_last: assert property (p_tab_last) else $error("last page fetch wrong");

  property p_xor_acc;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_XOR_TO_ACC) |=>
      acc == ($past(acc) ^ $past(ram_rdata)) && flags[`MAS_FLAG_Z] == (acc == 8'h00)
      && flags[`MAS_FLAG_C] == $past(flags[`MAS_FLAG_C]);
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("exclusive-OR wrong");

  property p_xor_mem;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_EXCLUSIVE_OR_TO_MEM) |->
      ram_we && ram_wdata == (acc ^ ram_rdata) ##1 acc == $past(acc)
      && flags[`MAS_FLAG_OVF] == $past(flags[`MAS_FLAG_OVF]);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("exclusive-OR store wrong");

  property p_xor_imm;
    @(posedge clk_in) disable iff (reset_in)
    (in_exec && op_q == OP_XOR_IMM) |=>
      acc == ($past(acc) ^ $past(lit_q)) && flags[`MAS_FLAG_AUX] == $past(flags[`MAS_FLAG_AUX]);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("exclusive-OR imm wrong");

endmodule

// file: pkg/mas_regs.svh
// Register offsets, field positions and reset values of the ALU/skip/table block
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

`define MAS_ADDR_ACC     12'h000
`define MAS_ADDR_FLAGS   12'h004
`define MAS_ADDR_TPTR    12'h008
`define MAS_ADDR_THIGH   12'h00c
`define MAS_ADDR_STATUS  12'h010
`define MAS_RAM_SEL      2'h1

`define MAS_RST_ACC      8'h00
`define MAS_RST_FLAGS    4'h0
`define MAS_RST_TPTR     8'h00
`define MAS_RST_THIGH    8'h00
`define MAS_RST_PROG     14'h0000

`define MAS_FLAG_C       0
`define MAS_FLAG_AUX     1
`define MAS_FLAG_Z       2
`define MAS_FLAG_OVF     3

`define MAS_STAT_BUSY    0
`define MAS_STAT_SKIP    1

`define MAS_LAST_PAGE    6'h3f

`endif

// file: pkg/mas_pkg.sv
// Types and shared arithmetic of the ALU/skip/table block
package mas_pkg;

  typedef enum logic [3:0] {
    OP_SUB_FROM_ACC,
    OP_SUBTRACT_TO_MEM,
    OP_SUB_IMM,
    OP_NIBBLE_EXCHANGE_MEM,
    OP_NIBBLE_EXCHANGE_TO_ACC,
    OP_SKIP_ON_ZERO,
    OP_SKIP_ON_BIT_ZERO,
    OP_TABLE_FETCH_CURRENT_PAGE,
    OP_TABLE_FETCH_LAST_PAGE,
    OP_XOR_TO_ACC,
    OP_EXCLUSIVE_OR_TO_MEM,
    OP_XOR_IMM
  } mas_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_DUMMY,
    ST_FETCH,
    ST_STORE
  } mas_state_t;

  typedef enum logic [1:0] {
    ALU_SUB,
    ALU_XOR,
    ALU_SWAP
  } mas_alu_mode_t;

  // Carry out and difference of a + ~b + 1
  function automatic logic [8:0] mas_sub(input logic [7:0] a, input logic [7:0] b);
    mas_sub = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction

  function automatic logic [7:0] mas_swap(input logic [7:0] b);
    mas_swap = {b[3:0], b[7:4]};
  endfunction

endpackage

// file: src/mas_data_ram.sv
// Data memory, 256 bytes, registered read port
`timescale 1ns/1ps
module mas_data_ram (
  input  wire logic       clk_in,
  input  wire logic       we_in,
  input  wire logic [7:0] waddr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic [7:0] raddr_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [0:255];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem[raddr_in];
  end
endmodule

// file: src/mas_alu.sv
// Subtract, exclusive-OR and nibble exchange with flag results
`timescale 1ns/1ps
module mas_alu (
  input  wire logic                   [7:0] a_in,
  input  wire logic                   [7:0] b_in,
  input  wire mas_pkg::mas_alu_mode_t       mode_in,
  output logic                        [7:0] result_out,
  output logic                              carry_out,
  output logic                              aux_out,
  output logic                              ovf_out,
  output logic                              zero_out
);
  import mas_pkg::*;

  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    diff     = mas_sub(a_in, b_in);
    low_diff = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + 5'h01;
    case (mode_in)
      ALU_SUB:  result_out = diff[7:0];
      ALU_XOR:  result_out = a_in ^ b_in;
      ALU_SWAP: result_out = mas_swap(b_in);
      default:  result_out = a_in;
    endcase
    carry_out = diff[8];
    aux_out   = low_diff[4];
    // Signed overflow: operands differ in sign and result sign follows b
    ovf_out   = (a_in[7] ^ b_in[7]) & (a_in[7] ^ diff[7]);
    zero_out  = (result_out == 8'h00);
  end
endmodule

// file: dv/mcu_alu_skip_table_ops_tb_top.sv
// Self-checking testbench of the subtract, exchange, skip, table and exclusive-OR unit
`timescale 1ns/1ps
`include "mas_regs.svh"
module mcu_alu_skip_table_ops_tb_top;
  import mas_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        op_valid;
  mas_op_t     op_code;
  logic [7:0]  op_addr;
  logic [2:0]  op_bit;
  logic [7:0]  op_literal;
  logic [13:0] pc;
  logic        op_ready;
  logic        op_done;
  logic        skip;
  logic        dummy;
  logic [13:0] prog_addr;
  logic [15:0] prog_data;
  logic [7:0]  acc;
  logic [3:0]  flags;
  logic [7:0]  thigh;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n_cyc;
  logic        saw_skip;
  logic        saw_dummy;
  logic        err_bit;
  logic [31:0] rd;

  mas_alu_exec u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .op_valid_in(op_valid),
    .op_code_in(op_code), .op_addr_in(op_addr), .op_bit_in(op_bit),
    .op_literal_in(op_literal), .pc_in(pc), .op_ready_out(op_ready),
    .op_done_out(op_done), .skip_out(skip), .dummy_cycle_out(dummy),
    .prog_addr_out(prog_addr), .prog_data_in(prog_data), .acc_out(acc),
    .flags_out(flags), .table_high_byte_out(thigh)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Program word unique to each address
  function automatic logic [15:0] rom(input logic [13:0] a);
    rom = {2'b01, a[13:8], a[7:0] ^ 8'h5a};
  endfunction

  // Synchronous program memory: word valid the cycle after its address
  always @(posedge clk_in) begin
    prog_data <= rom(prog_addr);
  end

  // Flags {ovf,z,aux,c} of a minus b
  function automatic logic [3:0] sub_f(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} + {1'b0, ~b} + 9'h001;
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    sub_f = {(a[7] ^ b[7]) & (r[7] ^ a[7]), r[7:0] == 8'h00, h[4], r[8]};
  endfunction

  task automatic complete_run();
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mem_wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, {2'b01, idx, 2'b00}, {24'h0, v});
  endtask

  task automatic run(input mas_op_t op, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] lit, input logic [13:0] p);
    @(posedge clk_in);
    op_valid <= 1'b1;
    op_code <= op;
    op_addr <= a;
    op_bit <= b;
    op_literal <= lit;
    pc <= p;
    do @(posedge clk_in); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    n_cyc = 0;
    saw_skip = 1'b0;
    saw_dummy = 1'b0;
    do begin
      @(posedge clk_in);
      n_cyc++;
      if (skip === 1'b1) saw_skip = 1'b1;
      if (dummy === 1'b1) saw_dummy = 1'b1;
    end while (op_done !== 1'b1 && n_cyc < 8);
    @(negedge clk_in);
  endtask

  // Memory is write-only on the bus, so read it back through the accumulator
  task automatic mem_rd(input logic [7:0] idx, output logic [7:0] v);
    apb(1'b1, `MAS_ADDR_ACC, 32'h0);
    run(OP_XOR_TO_ACC, idx, 3'h0, 8'h00, 14'h0);
    v = acc;
  endtask

  task automatic t_case(input mas_op_t op, input logic [7:0] a, m, lit, input logic [2:0] b,
                        input logic [3:0] f0, input logic [7:0] ea, em,
                        input logic [3:0] ef, input int ec, input logic es);
    logic [7:0] v;
    apb(1'b1, `MAS_ADDR_ACC, {24'h0, a});
    apb(1'b1, `MAS_ADDR_FLAGS, {28'h0, f0});
    mem_wr(8'h20, m);
    run(op, 8'h20, b, lit, 14'h0);
    chk_val(acc, ea);
    chk_val(flags, ef);
    chk_cnt(n_cyc, ec);
    chk_val(saw_skip, es);
    chk_val(saw_dummy, es);
    mem_rd(8'h20, v);
    chk_val(v, em);
  endtask

  task automatic t_regs();
    chk_val(acc, `MAS_RST_ACC);
    chk_val(flags, `MAS_RST_FLAGS);
    chk_val(thigh, `MAS_RST_THIGH);
    chk_val(prog_addr, `MAS_RST_PROG);
    chk_val({op_ready, op_done, skip, dummy}, 4'h8);
    apb(1'b0, `MAS_ADDR_TPTR, 32'h0);
    chk_val(rd, {24'h0, `MAS_RST_TPTR});
    apb(1'b1, `MAS_ADDR_FLAGS, 32'hffff_fff5);
    apb(1'b0, `MAS_ADDR_FLAGS, 32'h0);
    chk_val({err_bit, rd}, 33'h0_0000_0005);
    apb(1'b1, `MAS_ADDR_THIGH, 32'h0000_00ff);
    chk_val(err_bit, 1'b1);
    apb(1'b0, `MAS_ADDR_THIGH, 32'h0);
    chk_val({err_bit, rd}, 33'h0);
    apb(1'b1, `MAS_ADDR_STATUS, 32'h0000_0003);
    chk_val(err_bit, 1'b1);
    apb(1'b0, `MAS_ADDR_STATUS, 32'h0);
    chk_val({err_bit, rd}, 33'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk_val(err_bit, 1'b1);
    apb(1'b0, 12'h400, 32'h0);
    chk_val({err_bit, rd}, 33'h1_0000_0000);
  endtask

  task automatic t_subtract();
    logic [7:0] va [4] = '{8'h05, 8'h03, 8'h80, 8'h3c};
    logic [7:0] vm [4] = '{8'h03, 8'h05, 8'h01, 8'h3c};
    logic [7:0] d;
    logic [3:0] f;
    for (int i = 0; i < 4; i++) begin
      d = va[i] - vm[i];
      f = sub_f(va[i], vm[i]);
      t_case(OP_SUB_FROM_ACC, va[i], vm[i], 8'h00, 3'h0, 4'h0, d, vm[i], f, 2,
             1'b0);
      t_case(OP_SUBTRACT_TO_MEM, va[i], vm[i], 8'h00, 3'h0, 4'h6, va[i], d,
             {f[3], 2'b11, f[0]}, 2, 1'b0);
      t_case(OP_SUB_IMM, va[i], 8'h77, vm[i], 3'h0, 4'h0, d, 8'h77, f, 1,
             1'b0);
    end
  endtask

  task automatic t_swap();
    t_case(OP_NIBBLE_EXCHANGE_MEM, 8'h55, 8'ha7, 8'h00, 3'h0, 4'ha, 8'h55, 8'h7a, 4'ha,
           2, 1'b0);
    t_case(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h55, 8'h1e, 8'h00, 3'h0, 4'h5, 8'he1, 8'h1e, 4'h5,
           2, 1'b0);
  endtask

  task automatic t_skip();
    logic [7:0] m;
    m = 8'h5a;
    t_case(OP_SKIP_ON_ZERO, 8'h11, 8'h00, 8'h00, 3'h0, 4'h9, 8'h11, 8'h00, 4'h9, 3,
           1'b1);
    t_case(OP_SKIP_ON_ZERO, 8'h11, 8'h01, 8'h00, 3'h0, 4'h9, 8'h11, 8'h01, 4'h9, 2,
           1'b0);
    for (int i = 0; i < 8; i++) begin
      t_case(OP_SKIP_ON_BIT_ZERO, 8'h22, m, 8'h00, i[2:0], 4'h6, 8'h22, m, 4'h6,
             m[i] ? 2 : 3, ~m[i]);
    end
  endtask

  task automatic t_tab(input mas_op_t op, input logic [13:0] p, input logic [5:0] page);
    logic [7:0]  v;
    logic [15:0] w;
    w = rom({page, 8'hc4});
    apb(1'b1, `MAS_ADDR_TPTR, 32'h0000_00c4);
    apb(1'b1, `MAS_ADDR_FLAGS, 32'h0000_000b);
    run(op, 8'h31, 3'h0, 8'h00, p);
    chk_cnt(n_cyc, 2);
    chk_val(thigh, w[15:8]);
    chk_val(flags, 4'hb);
    mem_rd(8'h31, v);
    chk_val(v, w[7:0]);
  endtask

  task automatic t_table();
    t_tab(OP_TABLE_FETCH_CURRENT_PAGE, 14'h12f0, 6'h12);
    t_tab(OP_TABLE_FETCH_LAST_PAGE, 14'h12f0, `MAS_LAST_PAGE);
  endtask

  task automatic t_xor();
    t_case(OP_XOR_TO_ACC, 8'h5a, 8'h5a, 8'h00, 3'h0, 4'h3, 8'h00, 8'h5a, 4'h7, 2,
           1'b0);
    t_case(OP_XOR_TO_ACC, 8'h0f, 8'hf0, 8'h00, 3'h0, 4'hf, 8'hff, 8'hf0, 4'hb, 2,
           1'b0);
    t_case(OP_EXCLUSIVE_OR_TO_MEM, 8'h33, 8'h0f, 8'h00, 3'h0, 4'h4, 8'h33, 8'h3c, 4'h0,
           2, 1'b0);
    t_case(OP_EXCLUSIVE_OR_TO_MEM, 8'h81, 8'h81, 8'h00, 3'h0, 4'h9, 8'h81, 8'h00, 4'hd,
           2, 1'b0);
    t_case(OP_XOR_IMM, 8'hc3, 8'h44, 8'hc3, 3'h0, 4'ha, 8'h00, 8'h44, 4'he, 1,
           1'b0);
    t_case(OP_XOR_IMM, 8'hc3, 8'h44, 8'h3c, 3'h0, 4'h4, 8'hff, 8'h44, 4'h0, 1,
           1'b0);
  endtask

  initial begin
    reset_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    op_valid = 1'b0;
    op_code = OP_SUB_FROM_ACC;
    op_addr = 8'h00;
    op_bit = 3'h0;
    op_literal = 8'h00;
    pc = 14'h0000;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    t_regs();
    t_subtract();
    t_swap();
    t_skip();
    t_table();
    t_xor();
    complete_run();
  end
endmodule
